/* hdl/pin_group_ctrl.sv */
// Purpose: General-purpose pin controller with per-group registers and peripheral muxing.
// Assumes: Pins and peripheral signals are synchronous inputs at the aclk rate (40 MHz).
// Notes:   Pin drive is registered, so it follows a register write by one cycle.
// What this block does
// - Pins form groups of 32, each with registers
// - Direction bit one means output, zero input
// - Output pin drives its output_level bit
// - One pin_config register per pin, 00 to 31
// - input_value passes through a clocked resynchroniser
// - Synchronisers clock only when input is needed
// - Pin level readable as input or output
// - input_sample_enable zero stops sampling that pin
// - periph_mux_enable hands the pin to a peripheral
// - periph_function_select chooses the peripheral per pin
module pin_group_ctrl (
  // Clock and reset.
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [pin_ctrl_pkg::ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  input  wire logic [31:0]                            s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [pin_ctrl_pkg::ADDR_W-1:0]        s_axi_araddr,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  output logic [31:0]                                 s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready,
  // Physical pins, one bit per pin of each group.
  input  wire logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0] pin_i,
  output logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0]      pin_o,
  output logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0]      pin_oe,
  // Peripheral side: drive and enable per pin and function, and synchronised pin level.
  input  wire logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0][15:0] periph_o,
  input  wire logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0][15:0] periph_oe,
  output logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0]      pin_level
);
  import pin_ctrl_pkg::*;

  logic [NUM_GROUPS-1:0][31:0]             dir_q;
  logic [NUM_GROUPS-1:0][31:0]             out_q;
  logic [NUM_GROUPS-1:0]                   cont_q;
  logic [NUM_GROUPS-1:0][31:0][CFG_W-1:0]  cfg_q;
  logic [NUM_GROUPS-1:0][31:0][FSEL_W-1:0] fsel_q;
  logic [NUM_GROUPS-1:0][31:0]             sync1_q;
  logic [NUM_GROUPS-1:0][31:0]             sync2_q;
  logic [NUM_GROUPS-1:0][31:0]             samp_en;
  logic [ADDR_W-1:0]                       awaddr_q;
  logic [31:0]                             wdata_q;
  logic [3:0]                              wstrb_q;
  logic                                    aw_held_q;
  logic                                    w_held_q;
  logic                                    bvalid_q;
  logic [1:0]                              bresp_q;
  logic                                    wr_fire;
  logic                                    wr_grp;
  logic [7:0]                              wr_off;
  rd_state_t                               rd_state_q;
  logic [ADDR_W-1:0]                       araddr_q;
  logic [1:0]                              samp_cnt_q;
  logic [31:0]                             rdata_q;
  logic [1:0]                              rresp_q;
  logic                                    rd_grp;

  // Only the direction, output level, IN_VALUE, control, function-select and pin_config ranges are mapped.
  function automatic logic reg_mapped(input logic [7:0] off);
    reg_mapped = (off <= OFF_FSEL_END) || (off >= OFF_CFG_BASE);
  endfunction : reg_mapped

  // Merge write data into a word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = data[8*b +: 8];
      end
    end
  endfunction : merge

  // Write channel handshakes: address and data are taken independently.
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
  assign wr_grp        = awaddr_q[GROUP_BIT];
  assign wr_off        = awaddr_q[7:0];
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Capture write address and data, then answer once both are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= reg_mapped(wr_off) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register file; every group holds its own copy at its own base.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        dir_q[g]  <= DIRECTION_RST;
        out_q[g]  <= OUT_LEVEL_RST;
        cont_q[g] <= 1'b0;
        for (int p = 0; p < PINS; p++) begin
          cfg_q[g][p]  <= CFG_RST;
          fsel_q[g][p] <= FSEL_RST;
        end
      end
    end else if (wr_fire) begin
      if (wr_off == OFF_DIRECTION) begin
        dir_q[wr_grp] <= merge(dir_q[wr_grp], wdata_q, wstrb_q);
      end
      if (wr_off == OFF_OUT_LEVEL) begin
        out_q[wr_grp] <= merge(out_q[wr_grp], wdata_q, wstrb_q);
      end
      if (wr_off == OFF_SAMPLE_CTL && wstrb_q[0]) begin
        cont_q[wr_grp] <= wdata_q[SAMPLE_CONT_BIT];
      end
      // Function select: eight 4-bit fields per word, two per byte lane.
      if (wr_off >= OFF_FSEL_BASE && wr_off <= OFF_FSEL_END) begin
        for (int k = 0; k < FSEL_PER_REG; k++) begin
          if (wstrb_q[k/2]) begin
            fsel_q[wr_grp][{wr_off[3:2], 3'(k)}] <= wdata_q[FSEL_W*k +: FSEL_W];
          end
        end
      end
      // One pin_config word per pin, indexed by the pin's bit position.
      if (wr_off >= OFF_CFG_BASE && wstrb_q[0]) begin
        cfg_q[wr_grp][wr_off[6:2]] <= wdata_q[CFG_W-1:0];
      end
    end
  end

  // Read path: input_value waits while its synchronisers are clocked on demand.
  assign s_axi_arready = (rd_state_q == RD_IDLE);
  assign s_axi_rvalid  = (rd_state_q == RD_RESP);
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_grp        = araddr_q[GROUP_BIT];

  // Read value of a mapped offset; unmapped and reserved bits read as zero.
  function automatic logic [31:0] read_word(input logic g, input logic [7:0] off);
    read_word = '0;
    if (off == OFF_DIRECTION) begin
      read_word = dir_q[g];
    end else if (off == OFF_OUT_LEVEL) begin
      read_word = out_q[g];
    end else if (off == OFF_IN_VALUE) begin
      read_word = sync2_q[g];
    end else if (off == OFF_SAMPLE_CTL) begin
      read_word[SAMPLE_CONT_BIT] = cont_q[g];
    end else if (off >= OFF_FSEL_BASE && off <= OFF_FSEL_END) begin
      for (int k = 0; k < FSEL_PER_REG; k++) begin
        read_word[FSEL_W*k +: FSEL_W] = fsel_q[g][{off[3:2], 3'(k)}];
      end
    end else if (off >= OFF_CFG_BASE) begin
      read_word[CFG_W-1:0] = cfg_q[g][off[6:2]];
    end
  endfunction : read_word

  // Read state machine.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= RD_IDLE;
      araddr_q   <= '0;
      samp_cnt_q <= '0;
      rdata_q    <= '0;
      rresp_q    <= RESP_OKAY;
    end else begin
      unique case (rd_state_q)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            araddr_q <= s_axi_araddr;
            if (s_axi_araddr[7:0] == OFF_IN_VALUE && !cont_q[s_axi_araddr[GROUP_BIT]]) begin
              rd_state_q <= RD_SAMPLE;
              samp_cnt_q <= SAMPLE_CYCLES - 2'h1;
            end else begin
              rd_state_q <= RD_RESP;
              rdata_q    <= read_word(s_axi_araddr[GROUP_BIT], s_axi_araddr[7:0]);
              rresp_q    <= reg_mapped(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
            end
          end
        end
        RD_SAMPLE: begin
          if (samp_cnt_q == 2'h0) begin
            rd_state_q <= RD_RESP;
            rdata_q    <= sync2_q[rd_grp];
            rresp_q    <= RESP_OKAY;
          end else begin
            samp_cnt_q <= samp_cnt_q - 2'h1;
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_q <= RD_IDLE;
          end
        end
      endcase
    end
  end

  // Synchronisers run only for enabled pins, while continuous or a read needs them.
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      for (int p = 0; p < PINS; p++) begin
        samp_en[g][p] = cfg_q[g][p][CFG_INPUT_SAMPLE_ENABLE_BIT] &&
                        (cont_q[g] || (rd_state_q == RD_SAMPLE && rd_grp == 1'(g)));
      end
    end
  end

  // Two-stage resynchroniser; the pad is sampled whatever the pin direction.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        for (int p = 0; p < PINS; p++) begin
          if (samp_en[g][p]) begin
            sync1_q[g][p] <= pin_i[g][p];
            sync2_q[g][p] <= sync1_q[g][p];
          end
        end
      end
    end
  end
  assign pin_level = sync2_q;

  // Pin drive: own direction and level, or the selected peripheral when muxed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o  <= '0;
      pin_oe <= '0;
    end else begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        for (int p = 0; p < PINS; p++) begin
          if (cfg_q[g][p][CFG_MUX_BIT]) begin
            pin_oe[g][p] <= periph_oe[g][p][fsel_q[g][p]];
            pin_o[g][p]  <= periph_o[g][p][fsel_q[g][p]];
          end else begin
            pin_oe[g][p] <= dir_q[g][p];
            pin_o[g][p]  <= dir_q[g][p] && out_q[g][p];
          end
        end
      end
    end
  end

  // Checks on the pin and register behaviour.
  dir_drives_oe_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_q[0][0][CFG_MUX_BIT] |=> pin_oe[0][0] == $past(dir_q[0][0]))
    else $error("pin enable does not follow direction");
  out_level_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg_q[1][31][CFG_MUX_BIT] && dir_q[1][31]) |=> pin_o[1][31] == $past(out_q[1][31]))
    else $error("output pin does not follow output level");
  mux_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_q[0][5][CFG_MUX_BIT] |=> pin_oe[0][5] == $past(periph_oe[0][5][fsel_q[0][5]]))
    else $error("muxed pin not driven by peripheral enable");
  fsel_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_q[1][7][CFG_MUX_BIT] |=> pin_o[1][7] == $past(periph_o[1][7][fsel_q[1][7]]))
    else $error("muxed pin not driven by selected function");
  no_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_q[0][3][CFG_INPUT_SAMPLE_ENABLE_BIT] |=> $stable(sync1_q[0][3]) && $stable(sync2_q[0][3]))
    else $error("pin sampled with sampling disabled");
  sync_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (samp_en[0][2] [*2]) |=> sync2_q[0][2] == $past(pin_i[0][2], 2))
    else $error("input resynchroniser latency wrong");
  idle_no_clock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cont_q[1] && rd_state_q != RD_SAMPLE) |=> $stable(sync1_q[1]))
    else $error("synchroniser clocked without demand");
  in_read_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_state_q == RD_IDLE && s_axi_arvalid && s_axi_araddr[7:0] == OFF_IN_VALUE
     && !cont_q[s_axi_araddr[GROUP_BIT]]) |=> !s_axi_rvalid [*3] ##1 s_axi_rvalid)
    else $error("input_value read answered at wrong cycle");
  reset_state_a: assert property (@(posedge aclk)
    $past(!aresetn) |-> (pin_oe == '0 && pin_o == '0 && cfg_q == '0 && dir_q == '0))
    else $error("pins not idle after reset");
  cfg_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_off == 8'hFC && wstrb_q[0])
    |=> cfg_q[$past(wr_grp)][31] == $past(wdata_q[CFG_W-1:0]))
    else $error("pin_config 31 not written");
  group_apart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_grp) |=> $stable(dir_q[0]) && $stable(out_q[0]))
    else $error("write to group 1 changed group 0");
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  // Response holding, reset, commit, input_value answer and idle pin checks.
  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped before rready");
  reset_regs_a: assert property (@(posedge aclk)
    $past(!aresetn) |-> (out_q == '0 && cont_q == '0 && sync2_q == '0 && fsel_q == '0
                         && !s_axi_bvalid && !s_axi_rvalid))
    else $error("registers not cleared by reset");
  dir_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_off == OFF_DIRECTION && wstrb_q == 4'hF)
    |=> dir_q[$past(wr_grp)] == $past(wdata_q))
    else $error("pin_direction write lost");
  sample_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_state_q == RD_SAMPLE && samp_cnt_q == 2'h0)
    |=> s_axi_rvalid && s_axi_rdata == $past(sync2_q[rd_grp]))
    else $error("input_value answer is not the synchronised level");
  input_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg_q[0][0][CFG_MUX_BIT] && !dir_q[0][0]) |=> !pin_o[0][0] && !pin_oe[0][0])
    else $error("unmuxed input pin driven");
endmodule : pin_group_ctrl

/* hdl/pin_ctrl_pkg.sv */
// Purpose: Constants shared by the pin group controller.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes:   Each pin group owns a 0x100 byte window; the group index is address bit 8.
package pin_ctrl_pkg;
  localparam int          NUM_GROUPS     = 2;
  localparam int          PINS           = 32;
  localparam int          ADDR_W         = 9;
  localparam int          GROUP_BIT      = 8;
  localparam int          FSEL_W         = 4;
  localparam int          NUM_FUNCS      = 16;
  localparam int          FSEL_PER_REG   = 8;
  // Register offsets inside one group window.
  localparam logic [7:0]  OFF_DIRECTION  = 8'h00;
  localparam logic [7:0]  OFF_OUT_LEVEL  = 8'h04;
  localparam logic [7:0]  OFF_IN_VALUE   = 8'h08;
  localparam logic [7:0]  OFF_SAMPLE_CTL = 8'h0C;
  localparam logic [7:0]  OFF_FSEL_BASE  = 8'h10;
  localparam logic [7:0]  OFF_FSEL_END   = 8'h1C;
  localparam logic [7:0]  OFF_CFG_BASE   = 8'h80;
  // Field positions of pin_config and the sampling control register.
  localparam int          CFG_MUX_BIT    = 0;
  localparam int          CFG_INPUT_SAMPLE_ENABLE_BIT   = 1;
  localparam int          CFG_W          = 2;
  localparam int          SAMPLE_CONT_BIT = 0;
  // Reset values.
  localparam logic [31:0] DIRECTION_RST  = 32'h0000_0000;
  localparam logic [31:0] OUT_LEVEL_RST  = 32'h0000_0000;
  localparam logic [1:0]  CFG_RST        = 2'h0;
  localparam logic [3:0]  FSEL_RST       = 4'h0;
  // Cycles of on-demand synchroniser clocking before an input_value read answers.
  localparam logic [1:0]  SAMPLE_CYCLES  = 2'h3;
  // AXI responses.
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [1:0] {RD_IDLE, RD_SAMPLE, RD_RESP} rd_state_t;
endpackage : pin_ctrl_pkg

/* bench/pin_partner.sv */
// Purpose: Pad and peripheral model facing the pin controller.
// Assumes: Outside levels come from the bench; the pads have no pulls.
// Notes:   Peripheral drive is a fixed pattern that the bench predicts.
module pin_partner (
  // Controller drive and outside levels.
  input  wire logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0]       pin_o,
  input  wire logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0]       pin_oe,
  input  wire logic [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0]       ext_lvl,
  // Resolved pad level and peripheral signals.
  output logic      [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0]       pin_i,
  output logic      [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0][15:0] periph_o,
  output logic      [pin_ctrl_pkg::NUM_GROUPS-1:0][31:0][15:0] periph_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import pin_ctrl_pkg::*;

  // Peripheral drive level, varied over group, pin and function.
  function automatic logic fn_o(input int g, input int p, input int f);
    return logic'((g + p + f) % 2);
  endfunction : fn_o

  // Every third function leaves its pin undriven.
  function automatic logic fn_oe(input int f);
    return logic'(f % 3 != 0);
  endfunction : fn_oe

  // The pad follows the controller while it drives, else the outside level.
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++)
      for (int p = 0; p < PINS; p++) begin
        pin_i[g][p] = pin_oe[g][p] ? pin_o[g][p] : ext_lvl[g][p];
        for (int f = 0; f < NUM_FUNCS; f++) begin
          periph_o[g][p][f]  = fn_o(g, p, f);
          periph_oe[g][p][f] = fn_oe(f);
        end
      end
  end
endmodule : pin_partner

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the pin group controller.
// Assumes: Register access over AXI4-Lite; bready and rready rise once a response is seen.
// Notes:   Bus answers are checked against a queue of expected results.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_ctrl_pkg::*;
  typedef struct packed {logic [31:0] data; logic [1:0] resp;} note_t;
  logic                  aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                  s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic                  s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, lvl, en_m;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [NUM_GROUPS-1:0][31:0] pin_i, pin_o, pin_oe, pin_level, ext_lvl, dir_v, out_v;
  logic [NUM_GROUPS-1:0][31:0][15:0] periph_o, periph_oe;
  note_t                 bq[$], rq[$], nb, nr;
  int                    errors, n_tests, g, y, f, p;

  pin_group_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o,
    .pin_oe, .periph_o, .periph_oe, .pin_level);
  pin_partner u_pads (.pin_o, .pin_oe, .ext_lvl, .pin_i, .periph_o, .periph_oe);

  // Clock at 40 MHz.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // Compares one value with its expectation.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // A wait that runs out ends the run as a mismatch.
  task automatic bail();
    errors++;
    complete_run();
  endtask : bail

  // One write; address and data are each released once taken.
  task automatic wr(input int a, input logic [31:0] d, input logic [1:0] r);
    int k;
    bq.push_back('{d, r});
    s_axi_awaddr  <= ADDR_W'(a);
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 100) bail();
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  // One read; the answer is checked by the watcher below.
  task automatic rd(input int a, input logic [31:0] d, input logic [1:0] r);
    int k;
    rq.push_back('{d, r});
    s_axi_araddr  <= ADDR_W'(a);
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 100) bail();
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Takes the oldest expectation whenever the controller answers.
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      nb = bq.pop_front();
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, nb.resp});
    end
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      nr = rq.pop_front();
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, nr.resp});
      chk("rdata", s_axi_rdata, nr.data);
    end
  end

  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3C;
    ext_lvl = '0;
    errors = 0;
    n_tests = 0;
    void'($urandom(96));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset state of both groups, then random direction and level.
    chk("oe_rst", pin_oe[0] | pin_oe[1], 32'h0);
    for (g = 0; g < NUM_GROUPS; g++) begin
      rd(g * 256 + OFF_CFG_BASE + 124, 32'h0, RESP_OKAY);
      rd(g * 256 + OFF_FSEL_END, 32'h0, RESP_OKAY);
      rd(g * 256 + OFF_OUT_LEVEL, 32'h0, RESP_OKAY);
      dir_v[g] = $urandom;
      out_v[g] = $urandom;
      wr(g * 256 + OFF_DIRECTION, dir_v[g], RESP_OKAY);
      wr(g * 256 + OFF_OUT_LEVEL, out_v[g], RESP_OKAY);
    end
    repeat (3) @(posedge aclk);
    for (g = 0; g < NUM_GROUPS; g++) begin
      chk("pin_oe", pin_oe[g], dir_v[g]);
      chk("pin_o", pin_o[g], dir_v[g] & out_v[g]);
      rd(g * 256 + OFF_DIRECTION, dir_v[g], RESP_OKAY);
    end
    // Sampling enabled on a random subset of group 0, read on demand.
    en_m = $urandom;
    for (y = 0; y < PINS; y++) wr(OFF_CFG_BASE + 4 * y, {30'h0, en_m[y], 1'b0}, RESP_OKAY);
    ext_lvl <= {$urandom, $urandom};
    repeat (2) @(posedge aclk);
    lvl = (dir_v[0] & out_v[0]) | (~dir_v[0] & ext_lvl[0]);
    rd(OFF_IN_VALUE, lvl & en_m, RESP_OKAY);
    ext_lvl <= ~ext_lvl;
    repeat (6) @(posedge aclk);
    chk("idle_hold", pin_level[0], lvl & en_m);
    rd(OFF_IN_VALUE, ((dir_v[0] & out_v[0]) | (~dir_v[0] & ext_lvl[0])) & en_m, RESP_OKAY);
    wr(OFF_SAMPLE_CTL, 32'h1, RESP_OKAY);
    ext_lvl <= ~ext_lvl;
    repeat (5) @(posedge aclk);
    chk("continuous", pin_level[0], lvl & en_m);
    // Hand one pin of group 1 to every peripheral function in turn.
    p = $urandom % PINS;
    wr(OFF_CFG_BASE + 20, 32'h1, RESP_OKAY);
    wr(256 + OFF_CFG_BASE + 28, 32'h1, RESP_OKAY);
    wr(256 + OFF_CFG_BASE + 4 * p, 32'h1, RESP_OKAY);
    for (f = 0; f < NUM_FUNCS; f++) begin
      wr(256 + OFF_FSEL_BASE + 4 * (p / 8), 32'(f) << (4 * (p % 8)), RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("mux_oe", {31'h0, pin_oe[1][p]}, {31'h0, u_pads.fn_oe(f)});
      chk("mux_o", {31'h0, pin_o[1][p]}, {31'h0, u_pads.fn_o(1, p, f)});
    end
    wr(OFF_CFG_BASE + 20, 32'h0, RESP_OKAY);
    wr(256 + OFF_CFG_BASE + 28, 32'h0, RESP_OKAY);
    wr(256 + OFF_CFG_BASE + 4 * p, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("unmux_oe", pin_oe[1], dir_v[1]);
    // Unmapped offsets answer with an error.
    rd(256 + 32'h20, 32'h0, RESP_SLVERR);
    wr(32'h7C, 32'hFFFF_FFFF, RESP_SLVERR);
    // A second reset in mid-run restores the reset state.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe_rst2", pin_oe[0] | pin_oe[1] | pin_o[0] | pin_o[1], 32'h0);
    rd(OFF_DIRECTION, 32'h0, RESP_OKAY);
    rd(256 + OFF_CFG_BASE + 4 * p, 32'h0, RESP_OKAY);
    complete_run();
  end
endmodule : tb_top
